// *** src/ptq_pkg.sv ***
// Package for the PHY test-control and quick-poll status block.
// Assumes a single 100 MHz management-side clock and a parallel register port
// fed by the serial management frame decoder.
package ptq_pkg;
    // Register offsets (5-bit management register address)
    localparam logic [4:0] PTQ_ADDR_EXT_CTRL = 5'h10;
    localparam logic [4:0] PTQ_ADDR_QUICK_POLL = 5'h11;

    // Extended control field positions
    localparam int PTQ_EC_CIPHER_DIS = 0;
    localparam int PTQ_EC_INVALID_TX = 2;
    localparam int PTQ_EC_NRZI = 3;
    localparam int PTQ_EC_CIPHER_TEST = 5;

    // Extended control reset values
    localparam logic PTQ_EC_CIPHER_DIS_RST = 1'h0;
    localparam logic PTQ_EC_INVALID_TX_RST = 1'h0;
    localparam logic PTQ_EC_NRZI_RST = 1'h1;
    localparam logic PTQ_EC_CIPHER_TEST_RST = 1'h0;

    // Quick-poll field positions
    localparam int PTQ_QP_RATE = 15;
    localparam int PTQ_QP_DUPLEX = 14;
    localparam int PTQ_QP_MON_LO = 11;
    localparam int PTQ_QP_SIG_LOST = 10;
    localparam int PTQ_QP_PLL_ERR = 9;
    localparam int PTQ_QP_FALSE_CAR = 8;
    localparam int PTQ_QP_INV_SYM = 7;
    localparam int PTQ_QP_HALT = 6;
    localparam int PTQ_QP_PREM_END = 5;
    localparam int PTQ_QP_AN_DONE = 4;
    localparam int PTQ_QP_SIG_DET = 3;
    localparam int PTQ_QP_JABBER = 2;
    localparam int PTQ_QP_REM_FAULT = 1;
    localparam int PTQ_QP_LINK = 0;

    // Latch-high event bundle order (index into evt)
    localparam int PTQ_EVT_N = 8;

    // Quick-poll reset values
    localparam logic [7:0] PTQ_LATCH_HIGH_RST = 8'h00;
    localparam logic [2:0] PTQ_MON_RST = 3'h0;
    localparam logic PTQ_LINK_RST = 1'h0;

    // Scrambler: 11-bit stream cipher, taps 11 and 9, non-zero seed
    localparam int PTQ_LFSR_W = 11;
    localparam logic [10:0] PTQ_LFSR_SEED = 11'h7ff;

    // Transmit buffer depth and symbol widths
    localparam int PTQ_BUF_DEPTH = 2;
    localparam int PTQ_SYM_W = 5;
endpackage

// *** src/ptq_ctrl_status.sv ***
// Test-control and quick-poll status logic of a 10/100 Ethernet PHY.
// Assumes the management frame decoder delivers one-cycle read/write strobes
// with a register address, and that status inputs are on i_clk except the
// rate and duplex select pins, which are synchronised here.
//
// Notes on behaviour
// - Test bit clear: standard 4B/5B encoding only
// - Test bit and TX error: use test translation
// - Test map: low nibbles zero-extended, high nibbles tabled
// - Cipher bit clear: scrambler and descrambler active
// - Cipher bit set: both bypassed, unscrambled symbols
// - Scrambling only at 100 Mb/s
// - Quick-poll is 16-bit read-only, resets to defaults
// - Latch-high bits hold events until read
// - False carrier bit latches high
// - Halt symbol bit latches high
// - Remote fault bit latches high
// - Rate bit: pin in hardware, speed bit software
// - Rate bit: zero 10 Mb/s, one 100 Mb/s
// - Duplex bit: pin in hardware, control bit software
// - Duplex bit: zero half, one full
// - Progress monitor keeps highest negotiation state reached
// - Listed progress codes; completion sets done, code zero
// - Monitor clears on reset, disable, restart
`timescale 1ns/1ps
module ptq_ctrl_status
    import ptq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Register port from the management frame decoder
    input wire logic [4:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Mode selection
    input wire logic i_hw_mode,
    input wire logic i_rate_select_pin,
    input wire logic i_duplex_select_pin,
    input wire logic i_ctrl_speed,
    input wire logic i_ctrl_duplex,
    // Negotiation progress
    input wire logic i_an_enable,
    input wire logic i_an_restart,
    input wire logic [2:0] i_an_state,
    input wire logic i_an_complete,
    // Status conditions, high while present
    input wire logic i_sig_lost,
    input wire logic i_pll_err,
    input wire logic i_false_carrier,
    input wire logic i_invalid_sym,
    input wire logic i_halt_sym,
    input wire logic i_premature_end,
    input wire logic i_jabber,
    input wire logic i_remote_fault,
    input wire logic i_sig_detect,
    input wire logic i_link_ok,
    // Transmit nibble stream from the MAC
    input wire logic [3:0] i_tx_nibble,
    input wire logic i_tx_err,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    // Transmit code-group stream toward the line side
    output logic [4:0] o_tx_sym,
    output logic o_tx_valid,
    input wire logic i_tx_sym_ready,
    // Receive code-group stream, descrambled here
    input wire logic [4:0] i_rx_sym,
    input wire logic i_rx_valid,
    output logic [4:0] o_rx_sym,
    output logic o_rx_valid,
    // Extended control bits for neighbouring logic
    output logic o_nrzi_en,
    output logic o_cipher_test
);

    // Standard 4B/5B data code groups
    function automatic logic [4:0] enc_std(input logic [3:0] nib);
        case (nib)
            4'h0: enc_std = 5'h1e;
            4'h1: enc_std = 5'h09;
            4'h2: enc_std = 5'h14;
            4'h3: enc_std = 5'h15;
            4'h4: enc_std = 5'h0a;
            4'h5: enc_std = 5'h0b;
            4'h6: enc_std = 5'h0e;
            4'h7: enc_std = 5'h0f;
            4'h8: enc_std = 5'h12;
            4'h9: enc_std = 5'h13;
            4'ha: enc_std = 5'h16;
            4'hb: enc_std = 5'h17;
            4'hc: enc_std = 5'h1a;
            4'hd: enc_std = 5'h1b;
            4'he: enc_std = 5'h1c;
            default: enc_std = 5'h1d;
        endcase
    endfunction

    // Test translation used to force invalid and control code groups
    function automatic logic [4:0] enc_test(input logic [3:0] nib);
        case (nib)
            4'h8: enc_test = 5'h00;
            4'h9: enc_test = 5'h0d;
            4'ha: enc_test = 5'h0c;
            4'hb: enc_test = 5'h11;
            4'hc: enc_test = 5'h10;
            4'hd: enc_test = 5'h19;
            4'he: enc_test = 5'h18;
            4'hf: enc_test = 5'h1f;
            default: enc_test = {1'h0, nib};
        endcase
    endfunction

    // One symbol through the stream cipher; returns {next state, symbol}.
    // Used by both directions so the two stay bit-compatible.
    function automatic logic [15:0] cipher(input logic [10:0] st, input logic [4:0] sym);
        logic [10:0] s;
        logic [4:0] o;
        logic k;
        s = st;
        o = 5'h00;
        k = 1'h0;
        for (int i = 4; i >= 0; i--) begin
            k = s[10] ^ s[8];
            s = {s[9:0], k};
            o[i] = sym[i] ^ k;
        end
        cipher = {s, o};
    endfunction

    // Extended control storage
    logic cipher_dis;
    logic invalid_tx;
    logic nrzi;
    logic cipher_test;

    // Synchronised select pins; first stage read only by the second
    logic rate_pin_s1, rate_pin_s2;
    logic dpx_pin_s1, dpx_pin_s2;

    // Quick-poll state
    logic [7:0] latch_high_flag; // Latch-high bits, order 10..5, 2, 1
    logic [2:0] an_mon;
    logic link_flag;

    // Derived status
    logic rate_100;
    logic duplex_full;
    logic scramble_on;
    logic [15:0] quick_poll;
    logic [15:0] ext_ctrl;
    logic [7:0] latch_high_cond;
    logic rd_qp;
    logic wr_ec;

    // Cipher state for both directions and transmit buffer
    logic [10:0] tx_lfsr;
    logic [10:0] rx_lfsr;
    logic [4:0] tx_code;
    logic [15:0] tx_ciph;
    logic [15:0] rx_ciph;
    logic [4:0] buf_mem [PTQ_BUF_DEPTH];
    logic buf_wp;
    logic buf_rp;
    logic [1:0] buf_cnt;
    logic buf_push;
    logic buf_pop;

    assign rd_qp = i_reg_rd && (i_reg_addr == PTQ_ADDR_QUICK_POLL);
    assign wr_ec = i_reg_wr && (i_reg_addr == PTQ_ADDR_EXT_CTRL);

    // Two-flop synchronisers for the asynchronous select pins
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rate_pin_s1 <= 1'h0;
            rate_pin_s2 <= 1'h0;
            dpx_pin_s1 <= 1'h0;
            dpx_pin_s2 <= 1'h0;
        end else begin
            rate_pin_s1 <= i_rate_select_pin;
            rate_pin_s2 <= rate_pin_s1;
            dpx_pin_s1 <= i_duplex_select_pin;
            dpx_pin_s2 <= dpx_pin_s1;
        end
    end

    // Selected technology; reflects selection, not link state
    assign rate_100 = i_hw_mode ? rate_pin_s2 : i_ctrl_speed;
    assign duplex_full = i_hw_mode ? dpx_pin_s2 : i_ctrl_duplex;

    // Extended control writes; reserved bits are not stored, and software
    // is trusted to write them as zero
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cipher_dis <= PTQ_EC_CIPHER_DIS_RST;
            invalid_tx <= PTQ_EC_INVALID_TX_RST;
            nrzi <= PTQ_EC_NRZI_RST;
            cipher_test <= PTQ_EC_CIPHER_TEST_RST;
        end else if (wr_ec) begin
            cipher_dis <= i_reg_wdata[PTQ_EC_CIPHER_DIS];
            invalid_tx <= i_reg_wdata[PTQ_EC_INVALID_TX];
            nrzi <= i_reg_wdata[PTQ_EC_NRZI];
            cipher_test <= i_reg_wdata[PTQ_EC_CIPHER_TEST];
        end
    end

    assign o_nrzi_en = nrzi;
    assign o_cipher_test = cipher_test;

    // Latch-high conditions, in register bit order
    assign latch_high_cond = {i_sig_lost, i_pll_err, i_false_carrier, i_invalid_sym,
                      i_halt_sym, i_premature_end, i_jabber, i_remote_fault};

    // Latch-high bits: a present condition always wins over a read clear
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            latch_high_flag <= PTQ_LATCH_HIGH_RST;
        end else if (rd_qp) begin
            latch_high_flag <= latch_high_cond;
        end else begin
            latch_high_flag <= latch_high_flag | latch_high_cond;
        end
    end

    // Link bit latches low; a read re-arms it with the live state
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            link_flag <= PTQ_LINK_RST;
        end else if (rd_qp) begin
            link_flag <= i_link_ok;
        end else begin
            link_flag <= link_flag & i_link_ok;
        end
    end

    // Negotiation progress monitor: keeps the highest code reached.
    // A read reloads it with the live state so the next read starts fresh.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            an_mon <= PTQ_MON_RST;
        end else if (!i_an_enable || i_an_restart) begin
            an_mon <= PTQ_MON_RST;
        end else if (i_an_complete) begin
            an_mon <= PTQ_MON_RST;
        end else if (rd_qp) begin
            an_mon <= i_an_state;
        end else if (i_an_state > an_mon) begin
            an_mon <= i_an_state;
        end
    end

    // Register images; reserved and unimplemented bits read as zero
    always_comb begin
        quick_poll = 16'h0000;
        quick_poll[PTQ_QP_RATE] = rate_100;
        quick_poll[PTQ_QP_DUPLEX] = duplex_full;
        quick_poll[PTQ_QP_MON_LO +: 3] = an_mon;
        quick_poll[PTQ_QP_SIG_LOST:PTQ_QP_PREM_END] = latch_high_flag[7:2];
        quick_poll[PTQ_QP_AN_DONE] = i_an_enable & i_an_complete;
        quick_poll[PTQ_QP_SIG_DET] = i_sig_detect;
        quick_poll[PTQ_QP_JABBER] = latch_high_flag[1];
        quick_poll[PTQ_QP_REM_FAULT] = latch_high_flag[0];
        quick_poll[PTQ_QP_LINK] = link_flag;
        ext_ctrl = 16'h0000;
        ext_ctrl[PTQ_EC_CIPHER_DIS] = cipher_dis;
        ext_ctrl[PTQ_EC_INVALID_TX] = invalid_tx;
        ext_ctrl[PTQ_EC_NRZI] = nrzi;
        ext_ctrl[PTQ_EC_CIPHER_TEST] = cipher_test;
    end

    // Read data is captured at the strobe, before the read clears flags.
    // Writes to the quick-poll address are ignored (read-only)
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_rdata <= 16'h0000;
            o_reg_rvalid <= 1'h0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    PTQ_ADDR_EXT_CTRL: o_reg_rdata <= ext_ctrl;
                    PTQ_ADDR_QUICK_POLL: o_reg_rdata <= quick_poll;
                    default: o_reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Cipher runs only at 100 Mb/s and when not disabled
    assign scramble_on = rate_100 && !cipher_dis;

    // Code-group selection: test map only with both the bit and TX error
    assign tx_code = (invalid_tx && i_tx_err) ? enc_test(i_tx_nibble)
                                              : enc_std(i_tx_nibble);
    assign tx_ciph = cipher(tx_lfsr, tx_code);

    // Buffer handshake; ready drops when both entries are taken
    assign o_tx_ready = (buf_cnt != 2'h2);
    assign buf_push = i_tx_valid && o_tx_ready;
    assign buf_pop = o_tx_valid && i_tx_sym_ready;
    assign o_tx_valid = (buf_cnt != 2'h0);
    assign o_tx_sym = buf_mem[buf_rp];

    // Transmit cipher state advances once per accepted nibble while scrambling is on
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_lfsr <= PTQ_LFSR_SEED;
        end else if (buf_push && scramble_on) begin
            tx_lfsr <= tx_ciph[15:5];
        end
    end

    // Two-entry buffer storage; a stalled receiver loses no symbol
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            buf_mem[0] <= 5'h00;
            buf_mem[1] <= 5'h00;
            buf_wp <= 1'h0;
            buf_rp <= 1'h0;
        end else begin
            if (buf_push) begin
                buf_mem[buf_wp] <= scramble_on ? tx_ciph[4:0] : tx_code;
                buf_wp <= ~buf_wp;
            end
            if (buf_pop) begin
                buf_rp <= ~buf_rp;
            end
        end
    end

    // Occupancy count
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            buf_cnt <= 2'h0;
        end else if (buf_push && !buf_pop) begin
            buf_cnt <= buf_cnt + 2'h1;
        end else if (buf_pop && !buf_push) begin
            buf_cnt <= buf_cnt - 2'h1;
        end
    end

    // Receive descrambler; symbols pass straight through when bypassed.
    // No lock search here: the local sequence starts from the seed.
    assign rx_ciph = cipher(rx_lfsr, i_rx_sym);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_lfsr <= PTQ_LFSR_SEED;
            o_rx_sym <= 5'h00;
            o_rx_valid <= 1'h0;
        end else begin
            o_rx_valid <= i_rx_valid;
            if (i_rx_valid) begin
                o_rx_sym <= scramble_on ? rx_ciph[4:0] : i_rx_sym;
                if (scramble_on) begin
                    rx_lfsr <= rx_ciph[15:5];
                end
            end
        end
    end

endmodule

// *** tb/ptq_ctrl_status_properties.sv ***
// Timing checker for the test-control and quick-poll status block.
// Sees top-level ports only; bound into every instance of the block.
`timescale 1ns/1ps
module ptq_ctrl_status_chk
    import ptq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [4:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic i_hw_mode,
    input wire logic i_ctrl_speed,
    input wire logic i_false_carrier,
    input wire logic i_halt_sym,
    input wire logic i_remote_fault,
    input wire logic [4:0] i_rx_sym,
    input wire logic i_rx_valid,
    input wire logic [4:0] o_rx_sym,
    input wire logic o_rx_valid,
    input wire logic [4:0] o_tx_sym,
    input wire logic o_tx_valid,
    input wire logic i_tx_sym_ready,
    input wire logic o_tx_ready
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // Read of the status word
    wire logic qp_rd = i_reg_rd && (i_reg_addr == PTQ_ADDR_QUICK_POLL);
    // Read of a hole in the map
    wire logic hole_rd = i_reg_rd && (i_reg_addr > PTQ_ADDR_QUICK_POLL
        || i_reg_addr < PTQ_ADDR_EXT_CTRL);

    a_read_answers: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read got no answer");
    a_no_stray_answer: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("answer without read");
    a_hole_reads_zero: assert property (hole_rd |=> o_reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_false_car_held: assert property (qp_rd && $past(i_false_carrier)
        |=> o_reg_rdata[PTQ_QP_FALSE_CAR])
        else $error("false carrier lost");
    a_halt_sym_held: assert property ($rose(i_halt_sym) ##1 qp_rd
        |=> o_reg_rdata[PTQ_QP_HALT])
        else $error("halt symbol lost");
    a_rem_fault_held: assert property (qp_rd && $past(i_remote_fault)
        |=> o_reg_rdata[PTQ_QP_REM_FAULT])
        else $error("remote fault lost");
    a_rate_sw_mode: assert property (qp_rd && !i_hw_mode
        |=> o_reg_rdata[PTQ_QP_RATE] == $past(i_ctrl_speed))
        else $error("rate bit wrong in software mode");
    a_rx_plain_10m: assert property (i_rx_valid && !i_hw_mode && !i_ctrl_speed
        |=> o_rx_valid && o_rx_sym == $past(i_rx_sym))
        else $error("receive altered at 10 Mb/s");
    a_stall_holds_sym: assert property (o_tx_valid && !i_tx_sym_ready
        |=> o_tx_valid && $stable(o_tx_sym))
        else $error("symbol changed under stall");

    c_status_read: cover property (qp_rd ##1 o_reg_rvalid);
    c_buffer_full: cover property (!o_tx_ready);
    c_sink_stall: cover property (o_tx_valid && !i_tx_sym_ready);
endmodule

bind ptq_ctrl_status ptq_ctrl_status_chk i_ptq_ctrl_status_chk (.i_clk, .i_arst_n,
    .i_reg_addr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_hw_mode, .i_ctrl_speed,
    .i_false_carrier, .i_halt_sym, .i_remote_fault, .i_rx_sym, .i_rx_valid,
    .o_rx_sym, .o_rx_valid, .o_tx_sym, .o_tx_valid, .i_tx_sym_ready, .o_tx_ready);

// *** tb/ptq_line_model.sv ***
// Line-side sink model for the transmit code-group stream.
// Same clock as the block; the bench picks prompt or slow acceptance.
`timescale 1ns/1ps
module ptq_line_model (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_slow,
    output logic o_ready
);
    logic [1:0] phase; // Stall phase counter

    // Free-running phase, so slow mode takes one symbol in four
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
    // Never ready in reset, so nothing is taken before the block is up
    assign o_ready = i_arst_n && (!i_slow || phase == 2'h3);
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the test-control and quick-poll status block.
// One 100 MHz clock; the line-side sink model stalls on request.
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top
    import ptq_pkg::*;
;
    localparam logic [4:0] EC = PTQ_ADDR_EXT_CTRL;
    localparam logic [4:0] QP = PTQ_ADDR_QUICK_POLL;
    // Standard data code groups
    localparam logic [4:0] STD[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
        5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    // Test translation groups
    localparam logic [4:0] TST[16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
        5'h06, 5'h07, 5'h00, 5'h0d, 5'h0c, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1f};
    // Status bit of each event input, in evt order
    localparam logic [15:0] MASK[8] = '{16'h0400, 16'h0200, 16'h0100, 16'h0080,
        16'h0040, 16'h0020, 16'h0004, 16'h0002};
    int mismatches = 0;
    int tests_run = 0;
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic [4:0] i_reg_addr = 5'h00, i_rx_sym = 5'h00;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic i_hw_mode = 1'b0, i_rate_select_pin = 1'b0, i_duplex_select_pin = 1'b0;
    logic i_ctrl_speed = 1'b0, i_ctrl_duplex = 1'b0, i_an_enable = 1'b0;
    logic i_an_restart = 1'b0, i_an_complete = 1'b0, i_link_ok = 1'b0;
    logic [2:0] i_an_state = 3'h0;
    logic [7:0] evt = 8'h00; // Latching status conditions
    logic [3:0] i_tx_nibble = 4'h0;
    logic i_tx_err = 1'b0, i_tx_valid = 1'b0, i_rx_valid = 1'b0, slow = 1'b0, sig_det = 1'b0;
    logic hs; // Symbol taken at the coming edge
    logic [4:0] hsym;
    logic [4:0] q[$]; // Symbols seen at the line side
    logic [4:0] rq[$]; // Receive symbols after the descrambler
    wire logic i_tx_sym_ready, o_reg_rvalid, o_tx_ready, o_tx_valid, o_rx_valid;
    wire logic o_nrzi_en, o_cipher_test;
    wire logic [15:0] o_reg_rdata;
    wire logic [4:0] o_tx_sym, o_rx_sym;

    ptq_ctrl_status i_ptq_ctrl_status (.i_clk, .i_arst_n, .i_reg_addr, .i_reg_wr,
        .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_hw_mode,
        .i_rate_select_pin, .i_duplex_select_pin, .i_ctrl_speed, .i_ctrl_duplex,
        .i_an_enable, .i_an_restart, .i_an_state, .i_an_complete,
        .i_sig_lost(evt[0]), .i_pll_err(evt[1]), .i_false_carrier(evt[2]),
        .i_invalid_sym(evt[3]), .i_halt_sym(evt[4]), .i_premature_end(evt[5]),
        .i_jabber(evt[6]), .i_remote_fault(evt[7]), .i_sig_detect(sig_det), .i_link_ok,
        .i_tx_nibble, .i_tx_err, .i_tx_valid, .o_tx_ready, .o_tx_sym, .o_tx_valid,
        .i_tx_sym_ready, .i_rx_sym, .i_rx_valid, .o_rx_sym, .o_rx_valid, .o_nrzi_en,
        .o_cipher_test);
    ptq_line_model i_ptq_line_model (.i_clk, .i_arst_n, .i_slow(slow),
        .o_ready(i_tx_sym_ready));

    always #5 i_clk = ~i_clk;
    // Sample the handshake mid-cycle, so the edge update never races it
    always @(negedge i_clk) begin
        hs = o_tx_valid && i_tx_sym_ready;
        hsym = o_tx_sym;
        if (o_rx_valid) rq.push_back(o_rx_sym);
    end
    // Cipher keystream, x11+x9 from the all-ones seed, MSB first
    function automatic logic [4:0] key(inout logic [10:0] s);
        logic [4:0] k;
        for (int b = 4; b >= 0; b--) begin
            k[b] = s[10] ^ s[8];
            s = {s[9:0], k[b]};
        end
        return k;
    endfunction
    always @(posedge i_clk) if (hs) q.push_back(hsym);

    // Register write; one idle edge after, so strobes never merge
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        i_reg_addr <= a;
        i_reg_wdata <= v;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    // Register read, judged on the answer cycle
    task automatic chk_rd(input logic [4:0] a, input logic [15:0] e, input string n);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_clk);
        `CHK(n, e, o_reg_rvalid ? o_reg_rdata : 16'hxxxx)
        @(posedge i_clk);
    endtask
    // One nibble, held until the block takes it
    task automatic send(input logic [3:0] n, input logic e);
        logic r;
        i_tx_nibble <= n;
        i_tx_err <= e;
        i_tx_valid <= 1'b1;
        i_rx_sym <= {1'b0, n};
        i_rx_valid <= 1'b1;
        r = 1'b0;
        while (!r) begin
            @(negedge i_clk);
            r = o_tx_ready;
            @(posedge i_clk);
        end
    endtask
    // All sixteen nibbles; exact match, or proof of scrambling
    task automatic burst(input logic e, input logic [4:0] ex[16], input bit same,
        input string n);
        int diff;
        logic [10:0] s;
        logic [4:0] k;
        diff = 0;
        q.delete();
        rq.delete();
        for (int i = 0; i < 16; i++) send(4'(i), e);
        i_tx_valid <= 1'b0;
        i_rx_valid <= 1'b0;
        repeat (200) if (q.size() < 16) @(posedge i_clk);
        `CHK("count", 16, q.size())
        for (int i = 0; i < 16; i++) begin
            if (same) `CHK(n, ex[i], q[i])
            diff += int'(q[i] !== ex[i]);
        end
        if (!same) `CHK(n, 1'b1, diff > 0)
        s = PTQ_LFSR_SEED;
        // Receive side only at full pace, where one symbol arrives per nibble
        for (int i = 0; i < 16 && !slow; i++) begin
            k = 5'h00;
            if (!same) k = key(s);
            if (!same) `CHK(n, ex[i] ^ k, q[i])
            `CHK("rx path", {1'b0, 4'(i)} ^ k, rq[i])
        end
        $display("test %s done", n);
    endtask

    task automatic t_regs();
        `CHK("nrzi", 1'b1, o_nrzi_en)
        chk_rd(EC, 16'h0008, "ext reset");
        chk_rd(QP, 16'h0000, "status reset");
        wr(QP, 16'hffff);
        chk_rd(QP, 16'h0000, "status write");
        chk_rd(5'h05, 16'h0000, "hole");
        wr(EC, 16'h0028); // Reserved bits kept at defaults
        chk_rd(EC, 16'h0028, "ext rw");
        `CHK("cipher test", 1'b1, o_cipher_test)
        wr(EC, 16'h0008);
        $display("test regs done");
    endtask
    task automatic t_latch();
        for (int k = 0; k < 8; k++) begin
            evt[k] <= 1'b1;
            @(posedge i_clk);
            evt[k] <= 1'b0;
            chk_rd(QP, MASK[k], "latched");
            chk_rd(QP, 16'h0000, "cleared");
        end
        evt[2] <= 1'b1;
        @(posedge i_clk);
        chk_rd(QP, 16'h0100, "held");
        evt[2] <= 1'b0;
        chk_rd(QP, 16'h0100, "present at read");
        chk_rd(QP, 16'h0000, "gone");
        $display("test latch done");
    endtask
    task automatic t_link();
        i_link_ok <= 1'b1;
        @(posedge i_clk);
        chk_rd(QP, 16'h0000, "link from reset");
        chk_rd(QP, 16'h0001, "link up");
        i_link_ok <= 1'b0;
        @(posedge i_clk);
        i_link_ok <= 1'b1;
        @(posedge i_clk);
        chk_rd(QP, 16'h0000, "link dropped");
        chk_rd(QP, 16'h0001, "link back");
        sig_det <= 1'b1;
        @(posedge i_clk);
        chk_rd(QP, 16'h0009, "signal detect");
        sig_det <= 1'b0;
        $display("test link done");
    endtask
    task automatic t_mode();
        i_hw_mode <= 1'b1;
        i_rate_select_pin <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk_rd(QP, 16'h8001, "pin rate");
        i_rate_select_pin <= 1'b0;
        i_duplex_select_pin <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk_rd(QP, 16'h4001, "pin duplex");
        i_hw_mode <= 1'b0;
        i_ctrl_speed <= 1'b1;
        i_ctrl_duplex <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk_rd(QP, 16'hc001, "soft mode");
        i_ctrl_speed <= 1'b0;
        i_ctrl_duplex <= 1'b0;
        repeat (4) @(posedge i_clk);
        $display("test mode done");
    endtask
    task automatic t_mon();
        i_an_enable <= 1'b1;
        i_an_state <= 3'h3;
        @(posedge i_clk);
        i_an_state <= 3'h1;
        repeat (2) @(posedge i_clk);
        chk_rd(QP, 16'h1801, "highest kept");
        chk_rd(QP, 16'h0801, "reloaded");
        i_an_restart <= 1'b1;
        i_an_state <= 3'h0;
        @(posedge i_clk);
        i_an_restart <= 1'b0;
        @(posedge i_clk);
        chk_rd(QP, 16'h0001, "restart");
        i_an_state <= 3'h5;
        i_an_complete <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk_rd(QP, 16'h0011, "complete");
        i_an_enable <= 1'b0;
        i_an_complete <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk_rd(QP, 16'h0001, "disabled");
        $display("test monitor done");
    endtask
    task automatic t_tx();
        slow <= 1'b1;
        burst(1'b0, STD, 1'b1, "plain 10m");
        wr(EC, 16'h000c); // Test bit on, reserved at defaults
        burst(1'b1, TST, 1'b1, "test map");
        slow <= 1'b0;
        burst(1'b0, STD, 1'b1, "no tx error");
        wr(EC, 16'h0009);
        i_ctrl_speed <= 1'b1;
        repeat (2) @(posedge i_clk);
        burst(1'b0, STD, 1'b1, "bypass");
        wr(EC, 16'h0008);
        burst(1'b0, STD, 1'b0, "scrambled");
        i_ctrl_speed <= 1'b0;
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        t_regs();
        t_latch();
        t_link();
        t_mode();
        t_mon();
        t_tx();
        close_out();
    end
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        mismatches++;
        $display("watchdog expired");
        close_out();
    end
endmodule
